/* design/smcc_mode_ctrl.sv */
// Operating mode and system clock controller with AHB-Lite registers
//
// Contract
// R1: two run modes, four CPU-off modes
// R2: select 0 fast, 1-6 divided, 7 slow
// R3: normal mode runs every clock
// R4: slow mode runs CPU from slow clock
// R5: slow mode fast clock follows enable bit; select 0-6 holds it on regardless
// R6: stop with keeps 00 enters sleep
// R7: sleep slow oscillator follows watchdog enable
// R8: keeps 01 enter idle0 clock pattern
// R9: keeps 11 enter idle1, all clocks but the CPU clock run
// R10: keeps 10 enter idle2 clock pattern
// R11: bit 1 keeps fast oscillator when halted
// R12: bit 0 keeps slow oscillator when halted
// R13: clock control bits 4-2 read zero
// R14: oscillator enable bit, set after reset
// R15: enabling clears stable flag, then sets
// R16: oscillator control bits 7-2 read zero
// R17: stop sets powerdown, clears timeout flag
// R18: return to normal waits for stability
// R19: settling modelled as parameterised cycle count
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
module smcc_mode_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        halt_req,
  input  wire logic        wake_req,
  input  wire logic        wdt_enable,
  input  wire logic        wdt_timeout,
  input  wire logic        wdt_clear,
  input  wire logic        slow_osc_tick,
  output logic             cpu_run,
  output logic             sys_clk_on,
  output logic             fast_clk_on,
  output logic             slow_clk_on,
  output logic             slow_osc_clk_on,
  output logic             sys_tick,
  output logic             powerdown_flag,
  output logic             watchdog_timeout_flag,
  output logic             irq
);
  import smcc_pkg::*;

  smcc_osc_if osc ();

  smcc_mode_t  mode_reg;
  smcc_mode_t  mode_next;
  logic [2:0]  sys_clk_select_reg;
  logic        halt_fast_osc_keep_reg;
  logic        halt_slow_osc_keep_reg;
  logic        fast_osc_enable_reg;
  logic        restart_reg;
  logic        stable_q_reg;
  logic [2:0]  irq_mask_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_stat_next;
  logic [4:0]  gate_reg;
  logic [4:0]  gate_next;
  logic        tick_reg;
  logic        pdf_reg;
  logic        to_reg;
  logic        irq_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] hrdata_reg;
  logic        hreadyout_reg;
  logic        hresp_reg;
  logic [31:0] rd_word;
  logic        running;
  logic        accept;
  logic        halt_ev;
  logic        wake_ev;
  logic        fast_src;

  function automatic logic is_slow(input logic [2:0] sel);
    is_slow = (sel == SEL_SLOW);
  endfunction

  function automatic smcc_mode_t halt_target(input logic kf, input logic ks);
    unique case ({kf, ks}) // see R6 // see R11 // see R12
      2'b00: halt_target = M_SLEEP;
      2'b01: halt_target = M_IDLE0;
      2'b11: halt_target = M_IDLE1;
      2'b10: halt_target = M_IDLE2;
    endcase
  endfunction

  assign running = (mode_reg == M_NORMAL) || (mode_reg == M_SLOW); // see R1
  assign accept  = hsel && htrans[1] && hready;
  assign halt_ev = running && halt_req;
  assign wake_ev = !running && wake_req;

  // Fast oscillator is held on in run modes whenever a fast source is chosen
  assign osc.osc_on  = running ? (fast_osc_enable_reg || !is_slow(sys_clk_select_reg))
                               : halt_fast_osc_keep_reg; // see R5 // see R11
  assign osc.restart = restart_reg;
  assign osc.div_sel = sys_clk_select_reg;

  smcc_fast_osc u_fast_osc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .o       (osc.osc)
  );

  // AHB-Lite slave: writes take no wait state, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg   <= 1'b0;
      rd_pend_reg   <= 1'b0;
      addr_reg      <= OFF_NONE;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else if (ce) begin
      wr_pend_reg <= accept && hwrite;
      hresp_reg   <= 1'b0;
      if (accept) begin
        addr_reg <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : OFF_NONE;
      end
      if (rd_pend_reg) begin
        hrdata_reg    <= rd_word;
        hreadyout_reg <= 1'b1;
        rd_pend_reg   <= 1'b0;
      end else if (accept && !hwrite) begin
        rd_pend_reg   <= 1'b1;
        hreadyout_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000; // see R13 // see R16
    unique case (addr_reg)
      OFF_SYS_CTRL: begin
        rd_word[SEL_MSB:SEL_LSB] = sys_clk_select_reg;
        rd_word[KEEP_FAST_BIT]   = halt_fast_osc_keep_reg;
        rd_word[KEEP_SLOW_BIT]   = halt_slow_osc_keep_reg;
      end
      OFF_OSC_CTRL: begin
        rd_word[OSC_STABLE_BIT] = osc.stable; // see R18
        rd_word[OSC_EN_BIT]     = fast_osc_enable_reg;
      end
      OFF_IRQ_STAT: rd_word[2:0] = irq_stat_reg;
      OFF_IRQ_MASK: rd_word[2:0] = irq_mask_reg;
      OFF_MODE_STAT: begin
        rd_word[MODE_MSB:0] = mode_reg;
        rd_word[PDF_BIT]    = pdf_reg;
        rd_word[TO_BIT]     = to_reg;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Control registers; the stable bit is hardware-owned and ignores writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_clk_select_reg     <= SEL_RST;
      halt_fast_osc_keep_reg <= KEEP_RST;
      halt_slow_osc_keep_reg <= KEEP_RST;
      fast_osc_enable_reg    <= OSC_EN_RST; // see R14
      restart_reg            <= 1'b0;
      irq_mask_reg           <= IRQ_MASK_RST;
    end else if (ce) begin
      restart_reg <= 1'b0;
      if (wr_pend_reg) begin
        unique case (addr_reg)
          OFF_SYS_CTRL: begin
            sys_clk_select_reg     <= hwdata[SEL_MSB:SEL_LSB]; // see R2
            halt_fast_osc_keep_reg <= hwdata[KEEP_FAST_BIT];
            halt_slow_osc_keep_reg <= hwdata[KEEP_SLOW_BIT];
          end
          OFF_OSC_CTRL: begin
            fast_osc_enable_reg <= hwdata[OSC_EN_BIT];
            restart_reg         <= hwdata[OSC_EN_BIT] && !fast_osc_enable_reg; // see R15
          end
          OFF_IRQ_MASK: irq_mask_reg <= hwdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Normal mode is only entered on a settled fast oscillator
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      M_NORMAL, M_SLOW: begin
        if (halt_req) begin
          mode_next = halt_target(halt_fast_osc_keep_reg, halt_slow_osc_keep_reg);
        end else if (!is_slow(sys_clk_select_reg) && osc.stable) begin
          mode_next = M_NORMAL; // see R18
        end else begin
          mode_next = M_SLOW; // see R4
        end
      end
      M_SLEEP, M_IDLE0, M_IDLE1, M_IDLE2: begin
        if (wake_req) begin
          mode_next = (!is_slow(sys_clk_select_reg) && osc.stable) ? M_NORMAL : M_SLOW;
        end
      end
      default: mode_next = M_SLOW;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= M_SLOW;
    end else if (ce) begin
      mode_reg <= mode_next;
    end
  end

  // Gate order: cpu, system, fast, slow, slow oscillator
  always_comb begin
    unique case (mode_reg)
      M_NORMAL: gate_next = 5'h1f; // see R3
      M_SLOW:   gate_next = {2'b11, osc.osc_on, 2'b11}; // see R5
      M_SLEEP:  gate_next = {4'h0, wdt_enable}; // see R6 // see R7
      M_IDLE0:  gate_next = {1'b0, is_slow(sys_clk_select_reg), 3'b011}; // see R8
      M_IDLE1:  gate_next = 5'h0f; // see R9
      M_IDLE2:  gate_next = {1'b0, !is_slow(sys_clk_select_reg), 3'b101}; // see R10
      default:  gate_next = 5'h00;
    endcase
  end

  assign fast_src = !is_slow(sys_clk_select_reg) && (mode_reg != M_SLOW);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else if (ce) begin
      gate_reg <= gate_next;
      tick_reg <= gate_next[3] && (fast_src ? osc.div_tick : slow_osc_tick); // see R2 // see R4
    end
  end

  // Power-down and timeout flags; a timeout beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdf_reg <= 1'b0;
      to_reg  <= 1'b0;
    end else if (ce) begin
      if (halt_ev) begin
        pdf_reg <= 1'b1; // see R17
      end else if (wdt_clear) begin
        pdf_reg <= 1'b0;
      end
      if (wdt_timeout) begin
        to_reg <= 1'b1;
      end else if (halt_ev || wdt_clear) begin
        to_reg <= 1'b0; // see R17
      end
    end
  end

  // Events set sticky bits; a read clears them but a new event wins
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (rd_pend_reg && addr_reg == OFF_IRQ_STAT) begin
      irq_stat_next = 3'h0;
    end
    irq_stat_next[IRQ_STABLE] = irq_stat_next[IRQ_STABLE] || (osc.stable && !stable_q_reg);
    irq_stat_next[IRQ_HALT]   = irq_stat_next[IRQ_HALT] || halt_ev;
    irq_stat_next[IRQ_WAKE]   = irq_stat_next[IRQ_WAKE] || wake_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= 3'h0;
      stable_q_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else if (ce) begin
      irq_stat_reg <= irq_stat_next;
      stable_q_reg <= osc.stable;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  assign hrdata                = hrdata_reg;
  assign hreadyout             = hreadyout_reg;
  assign hresp                 = hresp_reg;
  assign cpu_run               = gate_reg[4];
  assign sys_clk_on            = gate_reg[3];
  assign fast_clk_on           = gate_reg[2];
  assign slow_clk_on           = gate_reg[1];
  assign slow_osc_clk_on       = gate_reg[0];
  assign sys_tick              = tick_reg;
  assign powerdown_flag        = pdf_reg;
  assign watchdog_timeout_flag = to_reg;
  assign irq                   = irq_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  cpu_off_a: assert property (ce && !running |=> !cpu_run) // see R1
    else $error("cpu clock running in a low-power mode");
  normal_all_a: assert property (ce && mode_reg == M_NORMAL |=> gate_reg == 5'h1f) // see R3
    else $error("normal mode did not run every clock");
  slow_tick_a: assert property (ce && mode_reg == M_SLOW && slow_osc_tick |=> sys_tick) // see R4
    else $error("slow mode missed a slow clock tick");
  slow_fast_a: assert property (ce && mode_reg == M_SLOW && is_slow(sys_clk_select_reg) // see R5
    |=> fast_clk_on == $past(fast_osc_enable_reg))
    else $error("slow mode fast clock ignores the enable bit");
  sleep_gate_a: assert property (ce && mode_reg == M_SLEEP // see R6
    |=> gate_reg[4:1] == 4'h0 && slow_osc_clk_on == $past(wdt_enable)) // see R7
    else $error("sleep mode clock gating wrong");
  idle0_gate_a: assert property (ce && mode_reg == M_IDLE0 // see R8
    |=> !fast_clk_on && slow_clk_on && sys_clk_on == is_slow($past(sys_clk_select_reg)))
    else $error("idle0 clock gating wrong");
  idle1_gate_a: assert property (ce && mode_reg == M_IDLE1 |=> gate_reg == 5'h0f) // see R9
    else $error("idle1 clock gating wrong");
  idle2_gate_a: assert property (ce && mode_reg == M_IDLE2 // see R10
    |=> fast_clk_on && !slow_clk_on && sys_clk_on == !is_slow($past(sys_clk_select_reg)))
    else $error("idle2 clock gating wrong");
  halt_entry_a: assert property (ce && halt_ev // see R11
    |=> mode_reg == halt_target($past(halt_fast_osc_keep_reg), $past(halt_slow_osc_keep_reg)))
    else $error("stop did not pick the keep-bit mode"); // see R12
  sys_zero_a: assert property (ce && rd_pend_reg && addr_reg == OFF_SYS_CTRL // see R13
    |=> hreadyout && hrdata[4:2] == 3'h0)
    else $error("clock control unused bits read nonzero");
  osc_zero_a: assert property (ce && rd_pend_reg && addr_reg == OFF_OSC_CTRL // see R16
    |=> hreadyout && hrdata[7:2] == 6'h00)
    else $error("oscillator control unused bits read nonzero");
  stable_clear_a: assert property (ce && restart_reg |=> !osc.stable) // see R15
    else $error("enable did not clear the stable flag");
  halt_flags_a: assert property (ce && halt_ev && !wdt_timeout // see R17
    |=> powerdown_flag && !watchdog_timeout_flag)
    else $error("stop did not update power-down flags");
  normal_wait_a: assert property (ce && running && !osc.stable |=> mode_reg != M_NORMAL) // see R18
    else $error("normal mode entered on unsettled oscillator");

  sleep_c: cover property (ce && halt_ev ##1 mode_reg == M_SLEEP);
  idle1_c: cover property (ce && halt_ev ##1 mode_reg == M_IDLE1);
  slow_to_normal_c: cover property (mode_reg == M_SLOW ##1 mode_reg == M_NORMAL);
  irq_c: cover property ($rose(irq));
endmodule

/* design/smcc_pkg.sv */
// Shared constants and types for the mode and system-clock controller
package smcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_SYS_CTRL  = 8'h00;
  localparam logic [7:0] OFF_OSC_CTRL  = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] OFF_MODE_STAT = 8'h10;
  localparam logic [7:0] OFF_NONE      = 8'hff;

  // Field positions
  localparam int SEL_MSB        = 7;
  localparam int SEL_LSB        = 5;
  localparam int KEEP_FAST_BIT  = 1;
  localparam int KEEP_SLOW_BIT  = 0;
  localparam int OSC_EN_BIT     = 0;
  localparam int OSC_STABLE_BIT = 1;
  localparam int MODE_MSB       = 5;
  localparam int PDF_BIT        = 8;
  localparam int TO_BIT         = 9;
  localparam int IRQ_STABLE     = 0;
  localparam int IRQ_HALT       = 1;
  localparam int IRQ_WAKE       = 2;

  // Select codes and reset values
  localparam logic [2:0] SEL_SLOW     = 3'h7;
  localparam logic [2:0] SEL_RST      = 3'h0;
  localparam logic       KEEP_RST     = 1'b0;
  localparam logic       OSC_EN_RST   = 1'b1;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Fast oscillator settling time
  localparam int CLK_PERIOD_NS = 100;
  localparam int STAB_TIME_NS  = 2000;
  localparam int STAB_CYC      = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STAB_CNT = 8'(STAB_CYC);

  typedef enum logic [5:0] {
    M_NORMAL = 6'h01,
    M_SLOW   = 6'h02,
    M_SLEEP  = 6'h04,
    M_IDLE0  = 6'h08,
    M_IDLE1  = 6'h10,
    M_IDLE2  = 6'h20
  } smcc_mode_t;
endpackage

/* design/smcc_osc_if.sv */
// Link between the mode controller and the fast oscillator model
`timescale 1ns/1ps
interface smcc_osc_if;
  logic       osc_on;
  logic       restart;
  logic [2:0] div_sel;
  logic       stable;
  logic       div_tick;
  modport ctrl (output osc_on, output restart, output div_sel, input stable, input div_tick);
  modport osc  (input osc_on, input restart, input div_sel, output stable, output div_tick);
endinterface

/* design/smcc_fast_osc.sv */
// Fast oscillator settling counter and system clock prescaler
`timescale 1ns/1ps
module smcc_fast_osc (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  smcc_osc_if.osc  o
);
  import smcc_pkg::*;

  logic [7:0] stab_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic       stable_reg;
  logic       tick_reg;

  assign o.stable   = stable_reg;
  assign o.div_tick = tick_reg;

  function automatic logic [5:0] div_mask(input logic [2:0] sel);
    div_mask = 6'((7'h01 << sel) - 7'h01);
  endfunction

  // Settling: flag drops whenever the oscillator is off or restarted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stab_cnt_reg <= 8'h00;
      stable_reg   <= 1'b0;
    end else if (ce) begin
      if (!o.osc_on || o.restart) begin // see R15
        stab_cnt_reg <= 8'h00;
        stable_reg   <= 1'b0;
      end else if (stab_cnt_reg != STAB_CNT) begin // see R19
        stab_cnt_reg <= stab_cnt_reg + 8'h01;
      end else begin
        stable_reg <= 1'b1;
      end
    end
  end

  // Prescaler runs only on a settled oscillator, so no runt ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 6'h00;
      tick_reg    <= 1'b0;
    end else if (ce) begin
      if (!stable_reg) begin
        div_cnt_reg <= 6'h00;
        tick_reg    <= 1'b0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 6'h01;
        tick_reg    <= (div_cnt_reg & div_mask(o.div_sel)) == div_mask(o.div_sel); // see R2
      end
    end
  end

  stab_count_a: assert property (@(posedge hclk) disable iff (!hresetn) // see R19
    $rose(stable_reg) |-> stab_cnt_reg == STAB_CNT)
    else $error("stable flag rose before the settling count");
  tick_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !stable_reg |=> !tick_reg)
    else $error("prescaler ticked on an unsettled oscillator");
endmodule

/* verif/smcc_mode_ctrl_test.sv */
// Self-checking testbench for the mode and system clock controller
`timescale 1ns/1ps
module smcc_mode_ctrl_test;
  import smcc_pkg::*;

  logic        hclk          = 1'b0;
  logic        hresetn       = 1'b0;
  logic        ce            = 1'b1;
  logic        hsel          = 1'b0;
  logic [31:0] haddr         = 32'h0;
  logic [1:0]  htrans        = 2'h0;
  logic        hwrite        = 1'b0;
  logic [2:0]  hsize         = 3'h2;
  logic [31:0] hwdata        = 32'h0;
  logic        halt_req      = 1'b0;
  logic        wake_req      = 1'b0;
  logic        wdt_enable    = 1'b0;
  logic        wdt_timeout   = 1'b0;
  logic        wdt_clear     = 1'b0;
  logic        slow_osc_tick = 1'b0;
  logic [3:0]  tick_div      = 4'h0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         cpu_run;
  wire         sys_clk_on;
  wire         fast_clk_on;
  wire         slow_clk_on;
  wire         slow_osc_clk_on;
  wire         sys_tick;
  wire         powerdown_flag;
  wire         watchdog_timeout_flag;
  wire         irq;
  wire  [4:0]  gates = {cpu_run, sys_clk_on, fast_clk_on, slow_clk_on, slow_osc_clk_on};
  int          error_cnt = 0;
  int          n_tests   = 0;
  logic [31:0] rd;

  smcc_mode_ctrl smcc_mode_ctrl_i (
    .hclk                  (hclk),
    .hresetn               (hresetn),
    .ce                    (ce),
    .hsel                  (hsel),
    .haddr                 (haddr),
    .htrans                (htrans),
    .hwrite                (hwrite),
    .hsize                 (hsize),
    .hwdata                (hwdata),
    .hready                (hreadyout),
    .hrdata                (hrdata),
    .hreadyout             (hreadyout),
    .hresp                 (hresp),
    .halt_req              (halt_req),
    .wake_req              (wake_req),
    .wdt_enable            (wdt_enable),
    .wdt_timeout           (wdt_timeout),
    .wdt_clear             (wdt_clear),
    .slow_osc_tick         (slow_osc_tick),
    .cpu_run               (cpu_run),
    .sys_clk_on            (sys_clk_on),
    .fast_clk_on           (fast_clk_on),
    .slow_clk_on           (slow_clk_on),
    .slow_osc_clk_on       (slow_osc_clk_on),
    .sys_tick              (sys_tick),
    .powerdown_flag        (powerdown_flag),
    .watchdog_timeout_flag (watchdog_timeout_flag),
    .irq                   (irq)
  );

  always #50 hclk = ~hclk;

  // Slow oscillator stand-in: one tick every 16 bus clocks
  always @(posedge hclk) begin
    tick_div      <= tick_div + 4'h1;
    slow_osc_tick <= (tick_div == 4'hf);
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // Wait for hready high at a rising edge; read data is taken at that same edge
  task automatic wait_ready(output logic [31:0] q);
    int   i;
    logic ok;
    i  = 0;
    ok = 1'b0;
    q  = 32'h0;
    while (!ok) begin
      @(posedge hclk);
      ok = (hreadyout === 1'b1);
      q  = hrdata;
      i++;
      if (!ok && i > 50) begin
        error_cnt++;
        $display("ERROR bus wait expected hready seen timeout");
        final_report();
      end
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_ready(rd);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  // Index 0 halt, 1 wake, 2 watchdog timeout, 3 watchdog clear
  task automatic pulse(input int which);
    @(posedge hclk);
    {halt_req, wake_req, wdt_timeout, wdt_clear} <= 4'b1000 >> which;
    @(posedge hclk);
    {halt_req, wake_req, wdt_timeout, wdt_clear} <= 4'h0;
  endtask

  initial begin : main
    int          cnt;
    logic [2:0]  sel;
    logic [5:0]  mode;
    logic [4:0]  eg;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;

    chk_rd("osc ctrl reset", OFF_OSC_CTRL, 32'h1);
    chk_rd("sys ctrl reset", OFF_SYS_CTRL, 32'h0);
    idle(30);
    chk_rd("osc settled", OFF_OSC_CTRL, 32'h3);
    chk_rd("mode after settle", OFF_MODE_STAT, 32'h1);
    chk("normal gates", 32'h1f, {27'h0, gates});
    end_test("reset");

    wr(OFF_SYS_CTRL, 32'hffffffff);
    chk_rd("sys ctrl unused", OFF_SYS_CTRL, 32'he3);
    wr(OFF_SYS_CTRL, 32'h0);
    wr(OFF_OSC_CTRL, 32'hfffffffe);
    chk_rd("osc ctrl unused", OFF_OSC_CTRL, 32'h2);
    wr(OFF_OSC_CTRL, 32'hffffffff);
    chk_rd("stable cleared", OFF_OSC_CTRL, 32'h1);
    idle(30);
    chk_rd("stable set", OFF_OSC_CTRL, 32'h3);
    wr(8'h20, 32'hffffffff);
    chk_rd("unmapped read", 8'h20, 32'h0);
    chk_rd("unmapped write", OFF_SYS_CTRL, 32'h0);
    end_test("registers");

    // Every select code; 256 cycles hold a whole number of periods of each
    for (int s = 0; s < 8; s++) begin
      wr(OFF_SYS_CTRL, {24'h0, s[2:0], 5'h0});
      idle(40);
      cnt = 0;
      repeat (256) begin
        @(negedge hclk);
        if (sys_tick === 1'b1) cnt++;
      end
      chk("sys tick count", (s == 7) ? 32'd16 : (32'd256 >> s), cnt);
    end
    chk_rd("slow mode", OFF_MODE_STAT, 32'h2);
    chk("slow gates", 32'h1f, {27'h0, gates});
    wr(OFF_OSC_CTRL, 32'h0);
    idle(3);
    chk("slow fast off", 32'h1b, {27'h0, gates});
    wr(OFF_SYS_CTRL, 32'h0);
    chk_rd("wait for osc", OFF_MODE_STAT, 32'h2);
    idle(30);
    chk_rd("back to normal", OFF_MODE_STAT, 32'h1);
    wr(OFF_OSC_CTRL, 32'h1);
    idle(30);
    end_test("clock select");

    for (int sl = 0; sl < 2; sl++) begin
      for (int k = 0; k < 4; k++) begin
        sel = (sl == 1) ? SEL_SLOW : 3'h0;
        @(posedge hclk);
        wdt_enable <= (sl == 0);
        wr(OFF_SYS_CTRL, {24'h0, sel, 3'h0, k[1:0]});
        idle(30);
        pulse(2);
        idle(2);
        chk("timeout set", 32'h1, {31'h0, watchdog_timeout_flag});
        pulse(0);
        idle(3);
        case (k)
          0: begin
            mode = 6'h04;
            eg   = {4'h0, (sl == 0)};
          end
          1: begin
            mode = 6'h08;
            eg   = {1'b0, sel == SEL_SLOW, 3'b011};
          end
          3: begin
            mode = 6'h10;
            eg   = 5'b01111;
          end
          default: begin
            mode = 6'h20;
            eg   = {1'b0, sel != SEL_SLOW, 3'b101};
          end
        endcase
        chk("halt gates", {27'h0, eg}, {27'h0, gates});
        chk_rd("halt mode", OFF_MODE_STAT, {22'h0, 2'b01, 2'h0, mode});
        pulse(1);
        idle(30);
        pulse(3);
        idle(2);
        chk("powerdown cleared", 32'h0, {31'h0, powerdown_flag});
        chk_rd("wake mode", OFF_MODE_STAT, (sl == 1) ? 32'h2 : 32'h1);
      end
    end
    end_test("halt modes");

    wr(OFF_SYS_CTRL, 32'h3);
    wr(OFF_IRQ_MASK, 32'h0);
    bus(1'b0, OFF_IRQ_STAT, 32'h0);
    idle(5);
    pulse(0);
    idle(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h7);
    chk_rd("mask readback", OFF_IRQ_MASK, 32'h7);
    idle(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    chk_rd("halt status", OFF_IRQ_STAT, 32'h2);
    idle(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    pulse(1);
    idle(3);
    chk("irq wake", 32'h1, {31'h0, irq});
    chk_rd("wake status", OFF_IRQ_STAT, 32'h4);
    idle(2);
    chk("irq cleared again", 32'h0, {31'h0, irq});
    end_test("interrupts");

    // A stop request while the enable is low must leave every flop untouched
    @(posedge hclk);
    ce <= 1'b0;
    pulse(0);
    idle(3);
    chk("frozen gates", 32'h1f, {27'h0, gates});
    chk("frozen irq", 32'h0, {31'h0, irq});
    @(posedge hclk);
    ce <= 1'b1;
    chk_rd("frozen mode", OFF_MODE_STAT, 32'h101);
    end_test("clock enable");

    final_report();
  end
endmodule
